// ### dv/ltd_host.sv
// Host model: serial register writer and external sync clock source
`timescale 1ns/1ns
module ltd_host (
  input  wire logic mclk,
  input  wire logic sync_on,
  input  wire logic sdio_wire,
  output logic      scl,
  output logic      sda,
  output logic      sync_clk
);
  int sync_cnt;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    sync_clk = 1'b0;
    sync_cnt = 0;
  end
  // ==========================================================
  // Sync clock at 1 MHz, still until enabled
  always @(posedge mclk) begin
    if (sync_on && sync_cnt == 49) begin
      sync_cnt <= 0;
      sync_clk <= ~sync_clk;
    end else if (sync_on) begin
      sync_cnt <= sync_cnt + 1;
    end
  end
  task automatic gap(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // ==========================================================
  // Write frame; ok only if all three bytes were acknowledged
  task automatic write(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d,
                       output logic ok);
    logic [23:0] frame;
    frame = {a, 1'b0, r, d};
    ok = 1'b1;
    gap(1);
    sda <= 1'b0;
    gap(8);
    scl <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      gap(4);
      sda <= frame[i];
      gap(4);
      scl <= 1'b1;
      gap(8);
      scl <= 1'b0;
      if (i % 8 == 0) begin
        gap(4);
        sda <= 1'b1;
        gap(4);
        scl <= 1'b1;
        gap(8);
        ok = ok & ~sdio_wire;
        scl <= 1'b0;
      end
    end
    gap(4);
    sda <= 1'b0;
    gap(4);
    scl <= 1'b1;
    gap(8);
    sda <= 1'b1;
    gap(8);
  endtask
endmodule

// ### dv/ltd_top_tb.sv
// Bench: register writes, steady and trapezoid sinks, enable pin, sync clock
`timescale 1ns/1ns
module ltd_top_tb;
  import ltd_pkg::*;
  // Short period keeps the run small
  localparam int P = 64;
  typedef struct {logic [7:0] r; logic [7:0] d; int e1; int e3; logic pmp;} ltd_row_t;
  ltd_row_t rows [6] = '{'{8'ha9, 8'h1f, 0, 0, 1'b0}, '{8'h10, 8'h01, P, 0, 1'b1},
    '{8'hc9, 8'h10, P, 0, 1'b1}, '{8'h10, 8'h05, P, 13, 1'b1},
    '{8'h10, 8'h07, P, 13, 1'b1}, '{8'h10, 8'h00, 0, 0, 1'b0}};
  logic [15:0] wave [4] = '{16'ha103, 16'h2009, 16'ha302, 16'h1008};
  logic mclk                = 1'b0;
  logic reset               = 1'b1;
  logic hardware_enable_pin = 1'b1;
  logic addr_sel            = 1'b0;
  logic sync_on             = 1'b0;
  logic scl, sda, sync_clk, sdio_out, sdio_oe, pump_on, ok;
  logic led_sink_one, led_sink_two, led_sink_three;
  wire  sdio_wire = sdio_oe ? sdio_out : sda;
  int   n_errors  = 0;
  int   n_tests   = 0;
  int   t;
  // High counts of the three sinks, longest high and low run of sink one
  int   st [5];
  always #5 mclk = ~mclk;
  ltd_top #(.PWM_PERIOD_CYCLES(P)) ltd_top_i (.mclk(mclk), .reset(reset),
    .hardware_enable_pin(hardware_enable_pin), .addr_sel(addr_sel), .sync_clk(sync_clk),
    .scl(scl), .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .led_sink_one(led_sink_one), .led_sink_two(led_sink_two),
    .led_sink_three(led_sink_three), .pump_on(pump_on));
  ltd_host ltd_host_i (.mclk(mclk), .sync_on(sync_on), .sdio_wire(sdio_wire), .scl(scl),
    .sda(sda), .sync_clk(sync_clk));
  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic measure(input int n);
    int h;
    int l;
    st = '{default: 0};
    h = 0;
    l = 0;
    // Sample between edges so the count never races the output flops
    repeat (n) begin
      @(negedge mclk);
      st[0] += (led_sink_one === 1'b1);
      st[1] += (led_sink_two === 1'b1);
      st[2] += (led_sink_three === 1'b1);
      h = (led_sink_one === 1'b1) ? h + 1 : 0;
      l = (led_sink_one === 1'b1) ? 0 : l + 1;
      st[3] = (h > st[3]) ? h : st[3];
      st[4] = (l > st[4]) ? l : st[4];
    end
    @(posedge mclk);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Sequence
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    repeat (5) @(posedge mclk);
    foreach (rows[k]) begin
      ltd_host_i.write(7'h18, rows[k].r, rows[k].d, ok);
      chk("ack", 1, ok);
      repeat (2 * P) @(posedge mclk);
      measure(P);
      chk("sink one", rows[k].e1, st[0]);
      chk("sink two", 0, st[1]);
      chk("sink three", rows[k].e3, st[2]);
      chk("pump", rows[k].pmp, pump_on);
    end
    ltd_host_i.write(7'h67, 8'h10, 8'h01, ok);
    chk("nack", 0, ok);
    measure(P);
    chk("refused write", 0, st[0]);
    addr_sel <= 1'b1;
    ltd_host_i.write(7'h67, 8'hb9, 8'h00, ok);
    chk("strap ack", 1, ok);
    addr_sel <= 1'b0;
    foreach (wave[k]) ltd_host_i.write(7'h18, wave[k][15:8], wave[k][7:0], ok);
    t = 0;
    while (led_sink_one !== 1'b1 && t < 2000) begin
      @(negedge mclk);
      t++;
    end
    // Pump settle 3..4 periods, delay 5..6, first level 1, less the stop tail
    chk("start delay", 1, t inside {[512:704]});
    if (t >= 2000) report_and_stop;
    chk("pump at start", 1, pump_on);
    measure(5000);
    chk("high hold", 1, st[3] inside {[384:512]});
    chk("low hold", 1, st[4] inside {[128:320]});
    hardware_enable_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("pin clears", 0, {pump_on, led_sink_one});
    hardware_enable_pin <= 1'b1;
    repeat (5) @(posedge mclk);
    ltd_host_i.write(7'h18, 8'h10, 8'h41, ok);
    measure(P);
    chk("default level", 0, st[0]);
    ltd_host_i.write(7'h18, 8'ha9, 8'h10, ok);
    sync_on <= 1'b1;
    measure(9600);
    chk("sync period", 1, st[3] inside {[550:750]});
    report_and_stop;
  end
endmodule

// ### rtl/ltd_channel.sv
// One LED sink: delay, trapezoid sequencer and PWM output stage
`timescale 1ns/1ns
module ltd_channel
  import ltd_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic               clr,
  input  wire logic               active,
  input  wire logic               wave_en,
  input  wire logic               start_ok,
  input  wire logic               pwm_tick,
  input  wire logic               step_tick,
  input  wire logic [2:0]         n_step,
  input  wire logic [PH_W-1:0]    phase,
  input  wire logic [PH_W-1:0]    period,
  input  wire logic [LVL_MSB:0]   hi,
  input  wire logic [LVL_MSB:0]   lo,
  input  wire logic [7:0]         dly,
  input  wire logic [7:0]         t_rise,
  input  wire logic [7:0]         t_high,
  input  wire logic [7:0]         t_fall,
  input  wire logic [7:0]         t_low,
  output logic                    drive
);
  ltd_wave_t          st, next_st;
  logic [LVL_MSB:0]   lvl, next_lvl, code;
  logic [CNT_W-1:0]   cnt, next_cnt;
  logic [CNT_W-1:0]   rise_len, fall_len, high_len, low_len;
  logic               go_rise, go_fall, next_drive;
  logic [23:0]        prod;
  logic [PH_W-1:0]    thresh;

  // ==========================================================
  // Phase lengths in PWM periods
  assign rise_len = (t_rise == 8'h00) ? 16'h0001 : (16'(t_rise) << n_step);
  assign fall_len = (t_fall == 8'h00) ? 16'h0001 : (16'(t_fall) << n_step);
  assign high_len = (16'(t_high) + 16'h0001) << n_step;
  assign low_len  = (16'(t_low) + 16'h0001) << n_step;

  // ==========================================================
  // Sequencer
  always_comb begin
    next_st  = st;
    next_lvl = lvl;
    next_cnt = cnt;
    go_rise  = 1'b0;
    go_fall  = 1'b0;
    if (!active || !wave_en) begin
      next_st  = W_IDLE;
      next_lvl = '0;
      next_cnt = '0;
    end else begin
      unique case (st)
        W_IDLE: if (start_ok) begin
          next_st  = W_DELAY;
          next_cnt = 16'(dly);
        end
        W_DELAY: if (cnt == '0) begin
          go_rise = 1'b1;
        end else if (step_tick) begin
          next_cnt = cnt - 16'h0001;
        end
        W_RISE: if (pwm_tick) begin
          if (cnt != '0) begin
            next_cnt = cnt - 16'h0001;
          end else if ({1'b0, lvl} + 6'h01 >= {1'b0, hi}) begin
            next_st  = W_HIGH;
            next_lvl = hi;
            next_cnt = high_len - 16'h0001;
          end else begin
            next_lvl = lvl + 5'h01;
            next_cnt = rise_len - 16'h0001;
          end
        end
        W_HIGH: if (pwm_tick) begin
          if (cnt != '0) next_cnt = cnt - 16'h0001;
          else go_fall = 1'b1;
        end
        W_FALL: if (pwm_tick) begin
          if (cnt != '0) begin
            next_cnt = cnt - 16'h0001;
          end else if ({1'b0, lvl} <= {1'b0, lo} + 6'h01) begin
            next_st  = W_LOW;
            next_lvl = lo;
            next_cnt = low_len - 16'h0001;
          end else begin
            next_lvl = lvl - 5'h01;
            next_cnt = fall_len - 16'h0001;
          end
        end
        W_LOW: if (pwm_tick) begin
          if (cnt != '0) next_cnt = cnt - 16'h0001;
          else go_rise = 1'b1;
        end
      endcase
      // Equal or inverted bounds skip the ramp entirely
      if (go_rise) begin
        if (hi > lo) begin
          next_st  = W_RISE;
          next_lvl = lo;
          next_cnt = rise_len - 16'h0001;
        end else begin
          next_st  = W_HIGH;
          next_lvl = hi;
          next_cnt = high_len - 16'h0001;
        end
      end
      if (go_fall) begin
        if (hi > lo) begin
          next_st  = W_FALL;
          next_lvl = hi;
          next_cnt = fall_len - 16'h0001;
        end else begin
          next_st  = W_LOW;
          next_lvl = lo;
          next_cnt = low_len - 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // PWM output stage
  always_comb begin
    if (!active) code = '0;
    else if (!wave_en) code = hi;
    else if (st == W_IDLE || st == W_DELAY) code = '0;
    else code = lvl;
  end
  assign prod       = {13'h0000, ltd_duty(code)} * {11'h000, period};
  assign thresh     = prod[22:10];
  assign next_drive = (code != '0) && (phase < thresh);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st    <= W_IDLE;
      lvl   <= '0;
      cnt   <= '0;
      drive <= 1'b0;
    end else if (clr) begin
      st    <= W_IDLE;
      lvl   <= '0;
      cnt   <= '0;
      drive <= 1'b0;
    end else begin
      st    <= next_st;
      lvl   <= next_lvl;
      cnt   <= next_cnt;
      drive <= next_drive;
    end
  end

  // ==========================================================
  // Checks
  sink_off_a: assert property (@(posedge mclk) disable iff (reset)
    !active |=> !drive) else $error("disabled sink drives");
  zero_code_a: assert property (@(posedge mclk) disable iff (reset)
    (code == '0) |=> !drive) else $error("code zero drives");
  steady_idle_a: assert property (@(posedge mclk) disable iff (reset)
    !wave_en |=> st == W_IDLE) else $error("sequencer runs with waveform off");
  wave_bounds_a: assert property (@(posedge mclk) disable iff (reset)
    (st inside {W_RISE, W_HIGH, W_FALL, W_LOW}) && hi > lo && $stable(hi) && $stable(lo)
    |-> lvl >= lo && lvl <= hi) else $error("level outside bounds");
  // Pin clear drops the sequencer to idle from any state
  delay_wait_a: assert property (@(posedge mclk) disable iff (reset || clr)
    st == W_DELAY && cnt != '0 && !step_tick && active && wave_en
    |=> st == W_DELAY && $stable(cnt)) else $error("delay advanced without step");
  hold_high_a: assert property (@(posedge mclk) disable iff (reset || clr)
    st == W_HIGH && active && wave_en && (!pwm_tick || cnt != '0)
    |=> st == W_HIGH) else $error("high hold ended early");
  wave_order_a: assert property (@(posedge mclk) disable iff (reset || clr)
    st == W_HIGH && pwm_tick && cnt == '0 && active && wave_en
    |=> st inside {W_FALL, W_LOW}) else $error("high not followed by fall");
  start_gate_a: assert property (@(posedge mclk) disable iff (reset)
    st == W_IDLE ##1 st == W_DELAY |-> $past(start_ok)) else $error("start before ready");
endmodule

// ### rtl/ltd_pkg.sv
// Shared constants, types and brightness table for the trapezoid LED dimmer
package ltd_pkg;
  // ==========================================================
  // Timing
  localparam int MCLK_PERIOD_NS = 10;
  localparam int PWM_PERIOD_NS  = 50000;
  localparam int PWM_CYC        = PWM_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int EXT_DIV        = 32;
  localparam int PUMP_SETTLE_TICKS = 4;
  localparam int PH_W           = 13;
  localparam int CNT_W          = 16;
  // ==========================================================
  // Register map
  localparam logic [7:0] REG_GP       = 8'h10;
  localparam logic [7:0] REG_TS       = 8'h20;
  localparam logic [3:0] CH_NIB_FIRST = 4'ha;
  localparam logic [3:0] OFS_DELAY    = 4'h1;
  localparam logic [3:0] OFS_TLOW     = 4'h2;
  localparam logic [3:0] OFS_THIGH    = 4'h3;
  localparam logic [3:0] OFS_TFALL    = 4'h4;
  localparam logic [3:0] OFS_TRISE    = 4'h5;
  localparam logic [3:0] OFS_LVL_LO   = 4'h8;
  localparam logic [3:0] OFS_LVL_HI   = 4'h9;
  localparam logic [7:0] GP_RESET     = 8'h00;
  localparam logic [7:0] TS_RESET     = 8'h88;
  localparam logic [7:0] LVL_RESET    = 8'he0;
  localparam logic [7:0] TIME_RESET   = 8'h00;
  localparam int GP_DIM_LSB  = 3;
  localparam int GP_EXT_BIT  = 6;
  localparam int GP_EARLY_BIT = 7;
  localparam int TS_N_MSB    = 2;
  localparam int LVL_MSB     = 4;
  // ==========================================================
  // Serial port addresses, picked by the address strap
  localparam logic [6:0] ADDR_LOW  = 7'h18;
  localparam logic [6:0] ADDR_HIGH = 7'h67;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {W_IDLE, W_DELAY, W_RISE, W_HIGH, W_FALL, W_LOW} ltd_wave_t;
  typedef enum logic [1:0] {S_IDLE, S_RECV, S_ACK, S_IGNORE} ltd_ser_t;
  // ==========================================================
  // Duty in 1/1024 of a period: 0.9^(31-code), code 0 is off
  function automatic logic [10:0] ltd_duty(input logic [4:0] code);
    logic [10:0] d;
    d = 11'h000;
    unique case (code)
      5'h00: d = 11'd0;    5'h01: d = 11'd43;   5'h02: d = 11'd48;   5'h03: d = 11'd54;
      5'h04: d = 11'd59;   5'h05: d = 11'd66;   5'h06: d = 11'd73;   5'h07: d = 11'd82;
      5'h08: d = 11'd91;   5'h09: d = 11'd101;  5'h0a: d = 11'd112;  5'h0b: d = 11'd124;
      5'h0c: d = 11'd138;  5'h0d: d = 11'd154;  5'h0e: d = 11'd171;  5'h0f: d = 11'd190;
      5'h10: d = 11'd211;  5'h11: d = 11'd234;  5'h12: d = 11'd260;  5'h13: d = 11'd289;
      5'h14: d = 11'd321;  5'h15: d = 11'd357;  5'h16: d = 11'd396;  5'h17: d = 11'd440;
      5'h18: d = 11'd489;  5'h19: d = 11'd544;  5'h1a: d = 11'd604;  5'h1b: d = 11'd671;
      5'h1c: d = 11'd746;  5'h1d: d = 11'd829;  5'h1e: d = 11'd921;  5'h1f: d = 11'd1024;
    endcase
    return d;
  endfunction
endpackage

// ### rtl/ltd_top.sv
// Trapezoid LED dimmer: serial register port, timebase and three sinks
//
// Behaviour
// - Control bits 0..2 switch sinks one..three on at high brightness.
// - Control bits 3..5 enable the dimming waveform on sinks one..three.
// - Control bit 6 picks external sync clock (1) or internal clock (0).
// - Bit 7 low: output stage powered before waveform starts; high: may start early.
// - Sink current is full scale times 0.9 to the power (31 minus code).
// - Brightness code zero turns the sink fully off.
// - Dimming is PWM at an internal 20 kHz rate, duty set per sink.
// - With waveform on, high and low codes bound the waveform.
// - Time-step bits 0..2 hold N; step is 50 us times N plus one.
// - Time-step bits 3..7 have no function.
// - Each sink waits delay code times time step before its waveform starts.
// - Ramp lasts PWM period times 2^N times level span times ramp code; ramp code 0 gives one PWM period per level.
// - Hold lasts PWM period times 2^N times code plus one.
// - External clock mode: PWM period is 32 sync clocks.
// - Enable pin low returns all registers to defaults and disables the device.
`timescale 1ns/1ns
module ltd_top
  import ltd_pkg::*;
#(
  parameter int PWM_PERIOD_CYCLES = PWM_CYC
)(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic hardware_enable_pin,
  input  wire logic addr_sel,
  input  wire logic sync_clk,
  input  wire logic scl,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  output logic      led_sink_one,
  output logic      led_sink_two,
  output logic      led_sink_three,
  output logic      pump_on
);
  // ==========================================================
  // Pin synchronisers
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic hw_m, hw_s, sync_m, sync_s, sync_d, adr_m, adr_s;
  logic clr, scl_rise, scl_fall, start_c, stop_c, sync_rise;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {hw_m, hw_s}          <= 2'h0;
      {sync_m, sync_s, sync_d} <= 3'h0;
      {adr_m, adr_s}        <= 2'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sdio_in, sda_m, sda_s};
      {hw_m, hw_s}          <= {hardware_enable_pin, hw_m};
      {sync_m, sync_s, sync_d} <= {sync_clk, sync_m, sync_s};
      {adr_m, adr_s}        <= {addr_sel, adr_m};
    end
  end

  assign clr       = !hw_s;
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign start_c   = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c    = scl_s && scl_d && !sda_d && sda_s;
  assign sync_rise = sync_s && !sync_d;
  assign sdio_out  = 1'b0;

  // ==========================================================
  // Serial write port
  ltd_ser_t   ser_st, next_ser_st;
  logic [7:0] shreg, next_shreg, ptr, next_ptr;
  logic [3:0] bitcnt, next_bitcnt;
  logic [1:0] byte_idx, next_byte_idx;
  logic       next_oe, wr_en;
  logic [6:0] my_addr;

  assign my_addr = adr_s ? ADDR_HIGH : ADDR_LOW;

  always_comb begin
    next_ser_st   = ser_st;
    next_shreg    = shreg;
    next_ptr      = ptr;
    next_bitcnt   = bitcnt;
    next_byte_idx = byte_idx;
    next_oe       = sdio_oe;
    wr_en         = 1'b0;
    if (start_c) begin
      next_ser_st   = S_RECV;
      next_bitcnt   = 4'h0;
      next_byte_idx = 2'h0;
      next_oe       = 1'b0;
    end else if (stop_c) begin
      next_ser_st = S_IDLE;
      next_oe     = 1'b0;
    end else begin
      unique case (ser_st)
        S_IDLE, S_IGNORE: ;
        S_RECV: if (scl_rise) begin
          next_shreg  = {shreg[6:0], sda_s};
          next_bitcnt = bitcnt + 4'h1;
        end else if (scl_fall && bitcnt == 4'h8) begin
          next_ser_st = S_ACK;
          next_oe     = 1'b1;
          unique case (byte_idx)
            2'h0: if (shreg[7:1] != my_addr || shreg[0]) begin
              next_ser_st = S_IGNORE;
              next_oe     = 1'b0;
            end
            2'h1: next_ptr = shreg;
            2'h2: wr_en = 1'b1;
            2'h3: begin
              next_ser_st = S_IGNORE;
              next_oe     = 1'b0;
            end
          endcase
        end
        S_ACK: if (scl_fall) begin
          next_ser_st   = S_RECV;
          next_oe       = 1'b0;
          next_bitcnt   = 4'h0;
          next_byte_idx = byte_idx + 2'h1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ser_st   <= S_IDLE;
      shreg    <= 8'h00;
      ptr      <= 8'h00;
      bitcnt   <= 4'h0;
      byte_idx <= 2'h0;
      sdio_oe  <= 1'b0;
    end else if (clr) begin
      ser_st   <= S_IDLE;
      shreg    <= 8'h00;
      ptr      <= 8'h00;
      bitcnt   <= 4'h0;
      byte_idx <= 2'h0;
      sdio_oe  <= 1'b0;
    end else begin
      ser_st   <= next_ser_st;
      shreg    <= next_shreg;
      ptr      <= next_ptr;
      bitcnt   <= next_bitcnt;
      byte_idx <= next_byte_idx;
      sdio_oe  <= next_oe;
    end
  end

  // ==========================================================
  // Register file
  logic [7:0] gp, next_gp, ts, next_ts;
  logic [7:0] dly [3], tlo [3], thi [3], tfa [3], tup [3], llo [3], lhi [3];
  logic [7:0] n_dly [3], n_tlo [3], n_thi [3], n_tfa [3], n_tri [3], n_llo [3], n_lhi [3];

  always_comb begin
    next_gp = gp;
    next_ts = ts;
    for (int c = 0; c < 3; c++) begin
      n_dly[c] = dly[c];
      n_tlo[c] = tlo[c];
      n_thi[c] = thi[c];
      n_tfa[c] = tfa[c];
      n_tri[c] = tup[c];
      n_llo[c] = llo[c];
      n_lhi[c] = lhi[c];
      if (wr_en && ptr[7:4] == CH_NIB_FIRST + 4'(c)) begin
        unique case (ptr[3:0])
          OFS_DELAY:  n_dly[c] = shreg;
          OFS_TLOW:   n_tlo[c] = shreg;
          OFS_THIGH:  n_thi[c] = shreg;
          OFS_TFALL:  n_tfa[c] = shreg;
          OFS_TRISE:  n_tri[c] = shreg;
          OFS_LVL_LO: n_llo[c] = shreg;
          OFS_LVL_HI: n_lhi[c] = shreg;
          default: ;
        endcase
      end
    end
    if (wr_en && ptr == REG_GP) next_gp = shreg;
    // Upper step bits are stored but drive nothing
    if (wr_en && ptr == REG_TS) next_ts = shreg;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset || clr) begin
      gp <= GP_RESET;
      ts <= TS_RESET;
      for (int c = 0; c < 3; c++) begin
        dly[c] <= TIME_RESET;
        tlo[c] <= TIME_RESET;
        thi[c] <= TIME_RESET;
        tfa[c] <= TIME_RESET;
        tup[c] <= TIME_RESET;
        llo[c] <= LVL_RESET;
        lhi[c] <= LVL_RESET;
      end
    end else begin
      gp <= next_gp;
      ts <= next_ts;
      for (int c = 0; c < 3; c++) begin
        dly[c] <= n_dly[c];
        tlo[c] <= n_tlo[c];
        thi[c] <= n_thi[c];
        tfa[c] <= n_tfa[c];
        tup[c] <= n_tri[c];
        llo[c] <= n_llo[c];
        lhi[c] <= n_lhi[c];
      end
    end
  end

  // ==========================================================
  // Timebase and output stage power-up
  logic [PH_W-1:0] ph, next_ph, period;
  logic [2:0]      step_cnt, next_step_cnt, n_step;
  logic [2:0]      settle, next_settle;
  logic            pwm_tick, step_tick, adv, wrap, next_pump_on, pump_ready, start_ok;
  logic [2:0]      active, sink_drive;

  assign n_step = ts[TS_N_MSB:0];
  assign period = gp[GP_EXT_BIT] ? PH_W'(EXT_DIV) : PH_W'(PWM_PERIOD_CYCLES);
  assign adv    = gp[GP_EXT_BIT] ? sync_rise : 1'b1;
  assign wrap   = adv && (ph >= period - PH_W'(1));
  assign active = gp[2:0] | gp[GP_DIM_LSB+2:GP_DIM_LSB];
  assign pump_ready = (settle == 3'(PUMP_SETTLE_TICKS));
  // Early mode trades a soft start for quicker waveform launch
  assign start_ok = gp[GP_EARLY_BIT] || pump_ready;

  always_comb begin
    next_ph       = wrap ? '0 : (adv ? ph + PH_W'(1) : ph);
    next_step_cnt = step_cnt;
    if (wrap) next_step_cnt = (step_cnt >= n_step) ? 3'h0 : step_cnt + 3'h1;
    next_pump_on = |active;
    next_settle  = settle;
    if (!pump_on) next_settle = 3'h0;
    else if (pwm_tick && !pump_ready) next_settle = settle + 3'h1;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset || clr) begin
      ph        <= '0;
      step_cnt  <= 3'h0;
      pwm_tick  <= 1'b0;
      step_tick <= 1'b0;
      pump_on   <= 1'b0;
      settle    <= 3'h0;
    end else begin
      ph        <= next_ph;
      step_cnt  <= next_step_cnt;
      pwm_tick  <= wrap;
      step_tick <= wrap && (step_cnt >= n_step);
      pump_on   <= next_pump_on;
      settle    <= next_settle;
    end
  end

  // ==========================================================
  // Sinks
  for (genvar c = 0; c < 3; c++) begin : g_sink
    ltd_channel u_chan (
      .mclk      (mclk),
      .reset     (reset),
      .clr       (clr),
      .active    (active[c]),
      .wave_en   (gp[GP_DIM_LSB+c]),
      .start_ok  (start_ok),
      .pwm_tick  (pwm_tick),
      .step_tick (step_tick),
      .n_step    (n_step),
      .phase     (ph),
      .period    (period),
      .hi        (lhi[c][LVL_MSB:0]),
      .lo        (llo[c][LVL_MSB:0]),
      .dly       (dly[c]),
      .t_rise    (tup[c]),
      .t_high    (thi[c]),
      .t_fall    (tfa[c]),
      .t_low     (tlo[c]),
      .drive     (sink_drive[c])
    );
  end
  assign led_sink_one   = sink_drive[0];
  assign led_sink_two   = sink_drive[1];
  assign led_sink_three = sink_drive[2];

  // ==========================================================
  // Checks
  pin_clear_a: assert property (@(posedge mclk) disable iff (reset)
    !hw_s |=> gp == GP_RESET && ts == TS_RESET && !sdio_oe) else $error("no clear on pin");
  ext_hold_a: assert property (@(posedge mclk) disable iff (reset || clr)
    gp[GP_EXT_BIT] && !sync_rise |=> ph == $past(ph)) else $error("phase moved without sync");
  ext_wrap_a: assert property (@(posedge mclk) disable iff (reset || clr)
    gp[GP_EXT_BIT] && sync_rise && ph == PH_W'(EXT_DIV - 1) |=> ph == '0 && pwm_tick)
    else $error("external period not 32");
  step_align_a: assert property (@(posedge mclk) disable iff (reset || clr)
    step_tick |-> pwm_tick) else $error("step off period");
  step_min_a: assert property (@(posedge mclk) disable iff (reset || clr)
    pwm_tick && $past(n_step) == 3'h0 |-> step_tick) else $error("step N=0 not every period");
  write_ack_a: assert property (@(posedge mclk) disable iff (reset || clr)
    wr_en |=> sdio_oe && ser_st == S_ACK) else $error("data byte not acknowledged");
endmodule
